/* logic/ism_source_map.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Lines 0..39 are pin wake-up starts
// - Lines 0..11 follow port 0 pins 0..11
// - Lines 12..23 follow port 1 pins
// - Lines 24..35 follow port 2 pins
// - Lines 36..39 follow port 3 pins 0..3
// - Line 41 ORs first timer16 matches, capture
// - Line 46 UART, includes rx line status
// - UART line includes tx holding empty
// - UART line includes rx data ready
// - UART line includes character time-out
// - UART includes modem change, autobaud done
// - UART line includes autobaud time-out
module ism_source_map (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] port0_pin0,
  input wire logic [11:0] port1_pin0,
  input wire logic [11:0] port2_pin0,
  input wire logic [3:0] port3_pin0,
  input wire logic two_wire_controller,
  input wire ism_pkg::ism_timer_t timer16_first,
  input wire ism_pkg::ism_timer_t timer16_second,
  input wire ism_pkg::ism_timer_t timer32_first,
  input wire ism_pkg::ism_timer_t timer32_second,
  input wire ism_pkg::ism_ssp_t sync_serial_port,
  input wire ism_pkg::ism_uart_t uartFlags,
  input wire logic [ism_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [ism_pkg::NUM_LINES-1:0] irqLines,
  output logic irq
);
  localparam int HB = ism_pkg::HI_BITS;

  logic [ism_pkg::NUM_WAKE-1:0] pinSync;
  logic [ism_pkg::NUM_WAKE-1:0] wakeLines;
  logic [6:0] periphLines;
  logic [ism_pkg::NUM_LINES-1:0] rawLines;
  logic [ism_pkg::NUM_LINES-1:0] prevLines;
  logic [ism_pkg::NUM_LINES-1:0] status;
  logic [ism_pkg::NUM_LINES-1:0] enable;
  logic [ism_pkg::NUM_WAKE-1:0] wakeEnable;
  logic [ism_pkg::NUM_LINES-1:0] next_status;
  logic [63:0] rawWide;
  logic [63:0] statWide;
  logic [63:0] enWide;
  logic [63:0] wakeEnWide;
  wire [ism_pkg::NUM_LINES-1:0] riseEvent;
  wire [ism_pkg::NUM_LINES-1:0] clrMask;
  wire wrClrLo;
  wire wrClrHi;
  wire wrEnLo;
  wire wrEnHi;
  wire wrWakeLo;
  wire wrWakeHi;
  logic [31:0] readMux;

  // Pins are asynchronous; resync before any logic sees them
  ism_sync #(.WIDTH(ism_pkg::NUM_WAKE)) pinSyncer (
    .clk(clk),
    .nrst(nrst),
    .async({port3_pin0, port2_pin0, port1_pin0, port0_pin0}),
    .synced(pinSync)
  );

  // Bit index = line number: port0 at 0, port1 at 12, port2 at 24, port3 at 36
  assign wakeLines = pinSync & wakeEnable;

  ism_combine combiner (
    .twoWireStateChange(two_wire_controller),
    .timer16First(timer16_first),
    .timer16Second(timer16_second),
    .timer32First(timer32_first),
    .timer32Second(timer32_second),
    .sspFlags(sync_serial_port),
    .uartFlags(uartFlags),
    .periphLines(periphLines)
  );

  assign rawLines = {periphLines, wakeLines};

  // Lines are levels to the core; held in flops for clean timing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqLines <= '0;
    end else begin
      irqLines <= rawLines;
    end
  end

  // Sticky capture of rising edges for software polling and the summary irq
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prevLines <= '0;
    end else begin
      prevLines <= rawLines;
    end
  end

  assign riseEvent = rawLines & ~prevLines;

  assign wrClrLo = wr && (addr == ism_pkg::REG_CLR_LO);
  assign wrClrHi = wr && (addr == ism_pkg::REG_CLR_HI);
  assign wrEnLo = wr && (addr == ism_pkg::REG_EN_LO);
  assign wrEnHi = wr && (addr == ism_pkg::REG_EN_HI);
  assign wrWakeLo = wr && (addr == ism_pkg::REG_WAKE_EN_LO);
  assign wrWakeHi = wr && (addr == ism_pkg::REG_WAKE_EN_HI);

  assign clrMask = {(wrClrHi ? wdata[HB-1:0] : {HB{1'b0}}),
      (wrClrLo ? wdata : 32'h00000000)};

  // A new event in the clearing cycle survives the clear
  assign next_status = (status & ~clrMask) | riseEvent;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      enable <= {ism_pkg::EN_RESET[HB-1:0], ism_pkg::EN_RESET};
    end else begin
      if (wrEnLo) begin
        enable[31:0] <= wdata;
      end
      if (wrEnHi) begin
        enable[ism_pkg::NUM_LINES-1:32] <= wdata[HB-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wakeEnable <= {ism_pkg::WAKE_EN_RESET[ism_pkg::NUM_WAKE-33:0],
          ism_pkg::WAKE_EN_RESET};
    end else begin
      if (wrWakeLo) begin
        wakeEnable[31:0] <= wdata;
      end
      if (wrWakeHi) begin
        wakeEnable[ism_pkg::NUM_WAKE-1:32] <= wdata[ism_pkg::NUM_WAKE-33:0];
      end
    end
  end

  assign irq = |(status & enable);

  assign rawWide = {{(64 - ism_pkg::NUM_LINES){1'b0}}, rawLines};
  assign statWide = {{(64 - ism_pkg::NUM_LINES){1'b0}}, status};
  assign enWide = {{(64 - ism_pkg::NUM_LINES){1'b0}}, enable};
  assign wakeEnWide = {{(64 - ism_pkg::NUM_WAKE){1'b0}}, wakeEnable};

  // Clear registers are write-only and read as zero, as do unmapped addresses
  always_comb begin
    unique case (addr)
      ism_pkg::REG_RAW_LO: readMux = rawWide[31:0];
      ism_pkg::REG_RAW_HI: readMux = rawWide[63:32];
      ism_pkg::REG_STAT_LO: readMux = statWide[31:0];
      ism_pkg::REG_STAT_HI: readMux = statWide[63:32];
      ism_pkg::REG_EN_LO: readMux = enWide[31:0];
      ism_pkg::REG_EN_HI: readMux = enWide[63:32];
      ism_pkg::REG_WAKE_EN_LO: readMux = wakeEnWide[31:0];
      ism_pkg::REG_WAKE_EN_HI: readMux = wakeEnWide[63:32];
      default: readMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= readMux;
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

/* logic/ism_pkg.sv */
`default_nettype none
package ism_pkg;

  localparam int NUM_LINES = 47;
  localparam int NUM_WAKE = 40;
  localparam int PORT_PINS = 12;
  localparam int PORT3_PINS = 4;

  // Line numbers
  localparam int LINE_PORT0_BASE = 0;
  localparam int LINE_PORT1_BASE = 12;
  localparam int LINE_PORT2_BASE = 24;
  localparam int LINE_PORT3_BASE = 36;
  localparam int LINE_TWO_WIRE = 40;
  localparam int LINE_T16_FIRST = 41;
  localparam int LINE_T16_SECOND = 42;
  localparam int LINE_T32_FIRST = 43;
  localparam int LINE_T32_SECOND = 44;
  localparam int LINE_SSP = 45;
  localparam int LINE_UART = 46;

  // Vector offsets of the peripheral lines
  localparam logic [7:0] VEC_TWO_WIRE = 8'hA0;
  localparam logic [7:0] VEC_T16_FIRST = 8'hA4;
  localparam logic [7:0] VEC_T16_SECOND = 8'hA8;
  localparam logic [7:0] VEC_T32_FIRST = 8'hAC;
  localparam logic [7:0] VEC_T32_SECOND = 8'hB0;
  localparam logic [7:0] VEC_SSP = 8'hB4;
  localparam logic [7:0] VEC_UART = 8'hB8;

  // Register map (word addresses are byte offsets)
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_RAW_LO = 8'h00;
  localparam logic [7:0] REG_RAW_HI = 8'h04;
  localparam logic [7:0] REG_STAT_LO = 8'h08;
  localparam logic [7:0] REG_STAT_HI = 8'h0C;
  localparam logic [7:0] REG_CLR_LO = 8'h10;
  localparam logic [7:0] REG_CLR_HI = 8'h14;
  localparam logic [7:0] REG_EN_LO = 8'h18;
  localparam logic [7:0] REG_EN_HI = 8'h1C;
  localparam logic [7:0] REG_WAKE_EN_LO = 8'h20;
  localparam logic [7:0] REG_WAKE_EN_HI = 8'h24;
  localparam logic [31:0] WAKE_EN_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] EN_RESET = 32'h00000000;
  localparam int HI_BITS = NUM_LINES - 32;

  typedef struct packed {
    logic [3:0] match;
    logic capture0;
  } ism_timer_t;

  typedef struct packed {
    logic txHalfEmpty;
    logic rxHalfFull;
    logic rxTimeout;
    logic rxOverrun;
  } ism_ssp_t;

  typedef struct packed {
    logic rx_line_status_irq;
    logic tx_holding_empty_irq;
    logic rx_data_ready_irq;
    logic char_timeout_irq;
    logic modemChange;
    logic autobaud_done_irq;
    logic autobaud_timeout_irq;
  } ism_uart_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ism_bus_t;

endpackage
`default_nettype wire

/* logic/ism_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser, one per bit
module ism_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule
`default_nettype wire

/* logic/ism_combine.sv */
`timescale 1ns/100ps
`default_nettype none
// OR-reduces peripheral flags into lines 40..46
module ism_combine (
  input wire logic twoWireStateChange,
  input wire ism_pkg::ism_timer_t timer16First,
  input wire ism_pkg::ism_timer_t timer16Second,
  input wire ism_pkg::ism_timer_t timer32First,
  input wire ism_pkg::ism_timer_t timer32Second,
  input wire ism_pkg::ism_ssp_t sspFlags,
  input wire ism_pkg::ism_uart_t uartFlags,
  output logic [6:0] periphLines
);
  wire twoWireLine;
  wire t16FirstLine;
  wire t16SecondLine;
  wire t32FirstLine;
  wire t32SecondLine;
  wire sspLine;
  wire uartLine;

  assign twoWireLine = twoWireStateChange;
  // First 16-bit timer has matches 0..2 only
  assign t16FirstLine = (|timer16First.match[2:0]) | timer16First.capture0;
  // Second 16-bit timer has matches 0..1 only
  assign t16SecondLine = (|timer16Second.match[1:0]) | timer16Second.capture0;
  assign t32FirstLine = (|timer32First.match) | timer32First.capture0;
  assign t32SecondLine = (|timer32Second.match) | timer32Second.capture0;
  assign sspLine = sspFlags.txHalfEmpty | sspFlags.rxHalfFull
      | sspFlags.rxTimeout | sspFlags.rxOverrun;
  assign uartLine = uartFlags.rx_line_status_irq
      | uartFlags.tx_holding_empty_irq
      | uartFlags.rx_data_ready_irq
      | uartFlags.char_timeout_irq
      | uartFlags.modemChange | uartFlags.autobaud_done_irq
      | uartFlags.autobaud_timeout_irq;

  assign periphLines = {uartLine, sspLine, t32SecondLine, t32FirstLine,
      t16SecondLine, t16FirstLine, twoWireLine};
endmodule
`default_nettype wire

/* sim/ism_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Pending bits latch like a core controller; only clrPend drops them
module ism_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [46:0] irqLines,
  input wire logic [46:0] clrPend,
  output logic [46:0] pending
);
  always_ff @(posedge clk) begin
    if (!nrst) pending <= '0;
    else pending <= (pending & ~clrPend) | irqLines;
  end
endmodule
`default_nettype wire

/* sim/ism_source_map_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module ism_source_map_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] port0_pin0,
  input wire logic [11:0] port1_pin0,
  input wire logic [11:0] port2_pin0,
  input wire logic [3:0] port3_pin0,
  input wire logic two_wire_controller,
  input wire ism_pkg::ism_timer_t timer16_first,
  input wire ism_pkg::ism_timer_t timer16_second,
  input wire ism_pkg::ism_timer_t timer32_first,
  input wire ism_pkg::ism_timer_t timer32_second,
  input wire ism_pkg::ism_ssp_t sync_serial_port,
  input wire ism_pkg::ism_uart_t uartFlags,
  input wire logic rd,
  input wire logic [ism_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic [31:0] rdata,
  input wire logic [ism_pkg::NUM_LINES-1:0] irqLines,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [39:0] pins;
  assign pins = {port3_pin0, port2_pin0, port1_pin0, port0_pin0};
  logic [ism_pkg::NUM_WAKE-1:0] wakeShadow;
  // Mirrors the per-pin wake gate so pin checks hold after software edits it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wakeShadow <= {ism_pkg::WAKE_EN_RESET[ism_pkg::NUM_WAKE-33:0],
          ism_pkg::WAKE_EN_RESET};
    end else begin
      if (wr && addr == ism_pkg::REG_WAKE_EN_LO) begin
        wakeShadow[31:0] <= wdata;
      end
      if (wr && addr == ism_pkg::REG_WAKE_EN_HI) begin
        wakeShadow[ism_pkg::NUM_WAKE-1:32] <= wdata[ism_pkg::NUM_WAKE-33:0];
      end
    end
  end
  property p_pins; irqLines[39:0] == ($past(pins, 3) & $past(wakeShadow)); endproperty
  a_pins: assert property (p_pins) else $error("pin lines wrong");
  property p_wire; irqLines[40] == $past(two_wire_controller); endproperty
  a_wire: assert property (p_wire) else $error("line 40 wrong");
  property p_t16a;
    irqLines[41] == $past(|{timer16_first.match[2:0], timer16_first.capture0});
  endproperty
  a_t16a: assert property (p_t16a) else $error("line 41 wrong");
  property p_t16b;
    irqLines[42] == $past(|{timer16_second.match[1:0], timer16_second.capture0});
  endproperty
  a_t16b: assert property (p_t16b) else $error("line 42 wrong");
  property p_t32; irqLines[44:43] == $past({|timer32_second, |timer32_first}); endproperty
  a_t32: assert property (p_t32) else $error("lines 43-44 wrong");
  property p_ssp; irqLines[45] == $past(|sync_serial_port); endproperty
  a_ssp: assert property (p_ssp) else $error("line 45 wrong");
  property p_uart; irqLines[46] == $past(|uartFlags); endproperty
  a_uart: assert property (p_uart) else $error("line 46 wrong");
  property p_rd; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  c_uart: cover property ($rose(irqLines[46]));
  c_pin: cover property ($rose(irqLines[39]));
  c_irq: cover property ($rose(irq));
endmodule
bind ism_source_map ism_source_map_checker i_ism_source_map_checker (
  .clk(clk), .nrst(nrst), .port0_pin0(port0_pin0), .port1_pin0(port1_pin0),
  .port2_pin0(port2_pin0), .port3_pin0(port3_pin0), .two_wire_controller(two_wire_controller),
  .timer16_first(timer16_first), .timer16_second(timer16_second),
  .timer32_first(timer32_first), .timer32_second(timer32_second),
  .sync_serial_port(sync_serial_port), .uartFlags(uartFlags), .rd(rd), .rdata(rdata),
  .addr(addr), .wdata(wdata), .wr(wr),
  .irqLines(irqLines), .irq(irq));
`default_nettype wire

/* sim/ism_source_map_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ism_source_map_tb;
  logic clk, nrst, wr, rd, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, periph;
  logic [39:0] pins;
  logic [46:0] irqLines, clrPend, pending;
  int mismatches, samples_checked;
  ism_source_map i_ism_source_map (.clk(clk), .nrst(nrst), .port0_pin0(pins[11:0]),
    .port1_pin0(pins[23:12]), .port2_pin0(pins[35:24]), .port3_pin0(pins[39:36]),
    .two_wire_controller(periph[31]), .timer16_first(periph[30:26]),
    .timer16_second(periph[25:21]), .timer32_first(periph[20:16]),
    .timer32_second(periph[15:11]), .sync_serial_port(periph[10:7]),
    .uartFlags(periph[6:0]), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irqLines(irqLines), .irq(irq));
  ism_core_model i_ism_core_model (.clk(clk), .nrst(nrst), .irqLines(irqLines),
    .clrPend(clrPend), .pending(pending));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Unused match bits of the 16-bit timers must stay off every line
  function automatic logic [46:0] line_of(input int k);
    if (k == 30 || k == 25 || k == 24) return '0;
    return 47'h1 << (k == 31 ? 40 : k >= 26 ? 41 : k >= 21 ? 42 : k >= 16 ? 43 :
      k >= 11 ? 44 : k >= 7 ? 45 : 46);
  endfunction
  task t_pins;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      pins <= 40'h1 << i;
      repeat (4) @(posedge clk);
      #1;
      chk(irqLines, 47'h1 << i);
      chk(pending[39:0], (64'h1 << (i + 1)) - 1);
    end
    @(posedge clk);
    pins <= 40'h0;
    repeat (4) @(posedge clk);
    clrPend <= 47'h7FFFFFFFFFFF;
    @(posedge clk);
    clrPend <= 47'h0;
    #1;
    chk(pending, 47'h0);
    $display("pins done");
  endtask
  task t_periph;
    for (int k = 0; k < 32; k++) begin
      @(posedge clk);
      periph <= 32'h1 << k;
      repeat (2) @(posedge clk);
      #1;
      chk(irqLines, line_of(k));
    end
    @(posedge clk);
    periph <= 32'h0;
    $display("periph done");
  endtask
  task t_irq;
    rd_chk(ism_pkg::REG_EN_LO, ism_pkg::EN_RESET);
    rd_chk(ism_pkg::REG_WAKE_EN_LO, ism_pkg::WAKE_EN_RESET);
    wr_reg(ism_pkg::REG_CLR_LO, 32'hFFFFFFFF);
    wr_reg(ism_pkg::REG_CLR_HI, 32'h00007FFF);
    rd_chk(ism_pkg::REG_STAT_HI, 32'h0);
    rd_chk(ism_pkg::REG_CLR_LO, 32'h0);
    rd_chk(8'h80, 32'h0);
    wr_reg(ism_pkg::REG_EN_HI, 32'h00004000);
    @(posedge clk);
    periph <= 32'h00000008;
    @(posedge clk);
    periph <= 32'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    rd_chk(ism_pkg::REG_STAT_HI, 32'h00004000);
    wr_reg(ism_pkg::REG_EN_HI, 32'h0);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wr_reg(ism_pkg::REG_EN_HI, 32'h00004000);
    @(posedge clk);
    #1;
    chk(irq, 1'b1);
    wr_reg(ism_pkg::REG_CLR_HI, 32'h00004000);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    $display("irq done");
  endtask
  // Pins 0 and 38 gated off; pins 1 and 39 pass
  task t_wake;
    wr_reg(ism_pkg::REG_WAKE_EN_LO, 32'hFFFFFFFE);
    wr_reg(ism_pkg::REG_WAKE_EN_HI, 32'h000000BF);
    rd_chk(ism_pkg::REG_WAKE_EN_LO, 32'hFFFFFFFE);
    rd_chk(ism_pkg::REG_WAKE_EN_HI, 32'h000000BF);
    @(posedge clk);
    pins <= 40'hC000000003;
    repeat (4) @(posedge clk);
    #1;
    chk(irqLines, 47'h8000000002);
    rd_chk(ism_pkg::REG_RAW_LO, 32'h00000002);
    rd_chk(ism_pkg::REG_RAW_HI, 32'h00000080);
    rd_chk(ism_pkg::REG_STAT_LO, 32'h00000002);
    wr_reg(ism_pkg::REG_EN_LO, 32'h00000001);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wr_reg(ism_pkg::REG_EN_LO, 32'h00000002);
    @(posedge clk);
    #1;
    chk(irq, 1'b1);
    @(posedge clk);
    pins <= 40'h0;
    wr_reg(ism_pkg::REG_EN_LO, 32'h0);
    wr_reg(ism_pkg::REG_WAKE_EN_LO, 32'hFFFFFFFF);
    wr_reg(ism_pkg::REG_WAKE_EN_HI, 32'h000000FF);
    wr_reg(ism_pkg::REG_CLR_LO, 32'hFFFFFFFF);
    wr_reg(ism_pkg::REG_CLR_HI, 32'h00007FFF);
    rd_chk(ism_pkg::REG_STAT_LO, 32'h0);
    rd_chk(ism_pkg::REG_STAT_HI, 32'h0);
    $display("wake done");
  endtask
  // Clear of line 46 lands in the cycle of its new rising edge
  task t_setwins;
    @(posedge clk);
    periph <= 32'h00000008;
    addr <= ism_pkg::REG_CLR_HI;
    wdata <= 32'h00004000;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    periph <= 32'h0;
    rd_chk(ism_pkg::REG_STAT_HI, 32'h00004000);
    chk(irq, 1'b1);
    wr_reg(ism_pkg::REG_CLR_HI, 32'h00004000);
    rd_chk(ism_pkg::REG_STAT_HI, 32'h0);
    chk(irq, 1'b0);
    $display("setwins done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    pins = 40'h0;
    periph = 32'h0;
    clrPend = 47'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_pins;
    t_periph;
    t_irq;
    t_wake;
    t_setwins;
    print_verdict;
  end
endmodule
`default_nettype wire
